// ===== rtl/asi_clock_cfg_cfg.svh
// constants for the serial-port controller clock setup and clock error block
`ifndef ASI_CLOCK_CFG_CFG_SVH
`define ASI_CLOCK_CFG_CFG_SVH

// register offsets
`define PRI_CLK_CFG_HI_ADDR 8'h38
`define PRI_RATIO_LO_ADDR 8'h39
`define SEC_CLK_CFG_HI_ADDR 8'h3a
`define SEC_RATIO_LO_ADDR 8'h3b
`define CLK_ERR_STS_A_ADDR 8'h3c
`define CLK_ERR_STS_B_ADDR 8'h3d

// reset values
`define CFG_HI_RESET 8'h00
`define RATIO_LO_RESET 8'h00
`define READ_IDLE_VALUE 8'h00

// fields of the two clock config registers
`define FRAMEGEN_INT_SEL_BIT 7
`define FRAMEGEN_INVERT_BIT 6
`define RATIO_HI_MSB 5

// fields of status register a
`define STS_A_RATIO_ERR_BIT 7
`define STS_A_SRC_ERR_BIT 4
`define STS_A_DEM_ERR_BIT 3
`define STS_A_PDM_ERR_BIT 2
`define STS_A_CLK_STOP_BIT 1

// fields of status register b
`define STS_B_PRI_RATIO_ERR_BIT 7
`define STS_B_SEC_RATIO_ERR_BIT 6

// least frame ratio a controller can generate
`define MIN_CTRL_RATIO 14'h0002

// audio clock stop detection time
`define CLK_STOP_TIME_NS 1000000
`define SYS_CLK_PERIOD_NS 40
`define CLK_STOP_CYCLES ((`CLK_STOP_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// ===== rtl/asi_clock_cfg_pkg.sv
// types shared by the serial-port clock setup block
`default_nettype none
package asi_clock_cfg_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [13:0] frame_ratio_t;
  typedef logic [1:0] port_bits_t;
endpackage
`default_nettype wire

// ===== rtl/asi_clock_cfg.sv
// controller-mode frame-sync generation and clock error status for both serial ports
`timescale 1ns/10ps
`default_nettype none
`include "asi_clock_cfg_cfg.svh"

module asi_clock_cfg #(
  parameter int unsigned STOP_CYCLES = `CLK_STOP_CYCLES
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // audio link clock, the external bit clock
  input wire logic ext_bit_clk,
  // register access port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire asi_clock_cfg_pkg::reg_byte_t reg_addr,
  input wire asi_clock_cfg_pkg::reg_byte_t reg_wdata,
  output logic [7:0] reg_rdata,
  // port mode selects, bit 0 primary, bit 1 secondary
  input wire asi_clock_cfg_pkg::port_bits_t controller_select,
  // clock-tree status from the rest of the device
  input wire logic rate_converter_ratio_bad,
  input wire logic custom_mn_ratio_en,
  input wire logic element_matching_rate_bad,
  input wire logic mic_clock_gen_bad,
  // frame-sync pins, bit 0 primary, bit 1 secondary
  input wire asi_clock_cfg_pkg::port_bits_t fsync_in,
  output logic [1:0] fsync_out,
  output logic [1:0] fsync_oe,
  // bit-clock pins driven in controller mode when the internal clock is used
  output logic [1:0] bclk_out,
  output logic [1:0] bclk_oe
);
  import asi_clock_cfg_pkg::*;

  localparam int unsigned STOP_W = $clog2(STOP_CYCLES + 1);

  if (STOP_CYCLES < 1 || STOP_CYCLES > 32'h00ff_ffff) begin : g_bad_stop
    $error("STOP_CYCLES out of range");
  end

  // register file, system domain
  reg_byte_t cfg_hi_ff [2];
  reg_byte_t ratio_lo_ff [2];
  reg_byte_t sts_a_ff;
  reg_byte_t sts_b_ff;
  reg_byte_t rdata_ff;
  reg_byte_t nxt_rdata;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_hi_ff[0] <= `CFG_HI_RESET;
      cfg_hi_ff[1] <= `CFG_HI_RESET;
      ratio_lo_ff[0] <= `RATIO_LO_RESET;
      ratio_lo_ff[1] <= `RATIO_LO_RESET;
    end else if (reg_wr_en) begin
      // status registers are read-only, writes there fall through
      unique case (reg_addr)
        `PRI_CLK_CFG_HI_ADDR: cfg_hi_ff[0] <= reg_wdata;
        `PRI_RATIO_LO_ADDR: ratio_lo_ff[0] <= reg_wdata;
        `SEC_CLK_CFG_HI_ADDR: cfg_hi_ff[1] <= reg_wdata;
        `SEC_RATIO_LO_ADDR: ratio_lo_ff[1] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr)
      `PRI_CLK_CFG_HI_ADDR: nxt_rdata = cfg_hi_ff[0];
      `PRI_RATIO_LO_ADDR: nxt_rdata = ratio_lo_ff[0];
      `SEC_CLK_CFG_HI_ADDR: nxt_rdata = cfg_hi_ff[1];
      `SEC_RATIO_LO_ADDR: nxt_rdata = ratio_lo_ff[1];
      `CLK_ERR_STS_A_ADDR: nxt_rdata = sts_a_ff;
      `CLK_ERR_STS_B_ADDR: nxt_rdata = sts_b_ff;
      default: nxt_rdata = `READ_IDLE_VALUE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `READ_IDLE_VALUE;
    end else if (reg_rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // per-port settings as one flat word for the crossing
  // layout: {ctrl, int_sel, invert, ratio[13:0]}
  logic [16:0] cfg_word [2];
  for (genvar p = 0; p < 2; p++) begin : g_cfg_word
    assign cfg_word[p] = {controller_select[p],
                          cfg_hi_ff[p][`FRAMEGEN_INT_SEL_BIT],
                          cfg_hi_ff[p][`FRAMEGEN_INVERT_BIT],
                          cfg_hi_ff[p][`RATIO_HI_MSB:0],
                          ratio_lo_ff[p]};
  end

  // link domain reset
  logic link_rst_s1_ff;
  logic link_rst_n_ff;

  // assert at once, release two link edges later
  always_ff @(posedge ext_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_s1_ff <= 1'b0;
      link_rst_n_ff <= 1'b0;
    end else begin
      link_rst_s1_ff <= 1'b1;
      link_rst_n_ff <= link_rst_s1_ff;
    end
  end

  // internal bit clock, half the link rate
  logic int_bclk_ff;
  always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      int_bclk_ff <= 1'b0;
    end else begin
      int_bclk_ff <= ~int_bclk_ff;
    end
  end

  // activity toggle for clock stop detection; it flips only after the
  // system side has echoed the last flip, so no rate ratio can alias it
  logic link_alive_ff;
  logic alive_s2_ff;
  logic echo_s1_ff;
  logic echo_s2_ff;
  always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      echo_s1_ff <= 1'b0;
      echo_s2_ff <= 1'b0;
      link_alive_ff <= 1'b0;
    end else begin
      echo_s1_ff <= alive_s2_ff;
      echo_s2_ff <= echo_s1_ff;
      link_alive_ff <= ~echo_s2_ff;
    end
  end

  // per-port link logic
  logic [1:0] ratio_err_link;

  for (genvar p = 0; p < 2; p++) begin : g_port
    // settings are quasi-static; a word is taken only once two
    // samples agree, so a write caught mid-flight is never used
    logic [16:0] cfg_s1_ff;
    logic [16:0] cfg_s2_ff;
    logic [16:0] cfg_s3_ff;
    logic [16:0] cfg_ff;
    logic fs_s1_ff;
    logic fs_s2_ff;
    logic fs_s3_ff;
    logic ctrl;
    logic int_sel;
    logic invert;
    frame_ratio_t ratio;
    logic tick;
    frame_ratio_t gen_cnt_ff;
    logic fs_gen_ff;
    logic oe_ff;
    logic bclk_oe_ff;
    frame_ratio_t meas_cnt_ff;
    logic seen_ff;
    logic err_ff;

    always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
      if (!link_rst_n_ff) begin
        cfg_s1_ff <= '0;
        cfg_s2_ff <= '0;
        cfg_s3_ff <= '0;
        cfg_ff <= '0;
      end else begin
        cfg_s1_ff <= cfg_word[p];
        cfg_s2_ff <= cfg_s1_ff;
        cfg_s3_ff <= cfg_s2_ff;
        if (cfg_s2_ff == cfg_s3_ff) begin
          cfg_ff <= cfg_s2_ff;
        end
      end
    end

    assign ctrl = cfg_ff[16];
    assign int_sel = cfg_ff[15];
    assign invert = cfg_ff[14];
    assign ratio = cfg_ff[13:0];

    // rising edges of the internal clock fall where it is low now;
    // inverting swaps to its falling edges, the pin itself is untouched
    always_comb begin
      if (int_sel) begin
        tick = invert ? int_bclk_ff : ~int_bclk_ff;
      end else begin
        // external clock: every link edge is one bit clock
        tick = 1'b1;
      end
    end

    // frame generator
    always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
      if (!link_rst_n_ff) begin
        gen_cnt_ff <= '0;
        fs_gen_ff <= 1'b0;
      end else if (!ctrl || ratio < `MIN_CTRL_RATIO) begin
        gen_cnt_ff <= '0;
        fs_gen_ff <= 1'b0;
      end else if (tick) begin
        if (gen_cnt_ff >= ratio - 14'h0001) begin
          gen_cnt_ff <= '0;
          fs_gen_ff <= 1'b1;
        end else begin
          gen_cnt_ff <= gen_cnt_ff + 14'h0001;
          fs_gen_ff <= 1'b0;
        end
      end
    end

    // pin drive follows the mode, bit clock only if made here
    always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
      if (!link_rst_n_ff) begin
        oe_ff <= 1'b0;
        bclk_oe_ff <= 1'b0;
      end else begin
        oe_ff <= ctrl;
        bclk_oe_ff <= ctrl & int_sel;
      end
    end

    assign fsync_out[p] = fs_gen_ff;
    assign fsync_oe[p] = oe_ff;
    // bit clock for other uses keeps its true polarity
    assign bclk_out[p] = int_bclk_ff;
    assign bclk_oe[p] = bclk_oe_ff;

    // incoming frame sync, pin to link domain
    always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
      if (!link_rst_n_ff) begin
        fs_s1_ff <= 1'b0;
        fs_s2_ff <= 1'b0;
        fs_s3_ff <= 1'b0;
      end else begin
        fs_s1_ff <= fsync_in[p];
        fs_s2_ff <= fs_s1_ff;
        fs_s3_ff <= fs_s2_ff;
      end
    end

    // ratio check: ticks between frame-sync rises against the setting;
    // first rise after a mode change only arms the check
    always_ff @(posedge ext_bit_clk or negedge link_rst_n_ff) begin
      if (!link_rst_n_ff) begin
        meas_cnt_ff <= '0;
        seen_ff <= 1'b0;
        err_ff <= 1'b0;
      end else if (ctrl) begin
        meas_cnt_ff <= '0;
        seen_ff <= 1'b0;
        err_ff <= (ratio < `MIN_CTRL_RATIO);
      end else if (fs_s2_ff && !fs_s3_ff) begin
        meas_cnt_ff <= {13'h0000, tick};
        seen_ff <= 1'b1;
        if (seen_ff && ratio != '0) begin
          err_ff <= (meas_cnt_ff != ratio);
        end
      end else if (tick && meas_cnt_ff != '1) begin
        meas_cnt_ff <= meas_cnt_ff + 14'h0001;
      end
    end

    assign ratio_err_link[p] = err_ff;
  end

  // link to system crossings
  logic [1:0] err_s1_ff;
  logic [1:0] err_s2_ff;
  logic alive_s1_ff;
  logic alive_s3_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_s1_ff <= 2'h0;
      err_s2_ff <= 2'h0;
      alive_s1_ff <= 1'b0;
      alive_s2_ff <= 1'b0;
      alive_s3_ff <= 1'b0;
    end else begin
      err_s1_ff <= ratio_err_link;
      err_s2_ff <= err_s1_ff;
      alive_s1_ff <= link_alive_ff;
      alive_s2_ff <= alive_s1_ff;
      alive_s3_ff <= alive_s2_ff;
    end
  end

  // audio clock stop detection
  // the echoed toggle works at any link rate; any change proves the clock alive
  logic [STOP_W-1:0] stop_cnt_ff;
  logic stopped_ff;
  logic link_edge_seen;

  assign link_edge_seen = alive_s2_ff ^ alive_s3_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_cnt_ff <= '0;
      stopped_ff <= 1'b0;
    end else if (link_edge_seen) begin
      stop_cnt_ff <= '0;
      stopped_ff <= 1'b0;
    end else if (stop_cnt_ff >= STOP_W'(STOP_CYCLES)) begin
      stopped_ff <= 1'b1;
    end else begin
      stop_cnt_ff <= stop_cnt_ff + STOP_W'(1);
    end
  end

  // status registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_a_ff <= '0;
      sts_b_ff <= '0;
    end else begin
      sts_a_ff <= '0;
      sts_a_ff[`STS_A_RATIO_ERR_BIT] <= |err_s2_ff;
      // no meaning under a custom m/n ratio, so held clear then
      sts_a_ff[`STS_A_SRC_ERR_BIT] <= rate_converter_ratio_bad & ~custom_mn_ratio_en;
      sts_a_ff[`STS_A_DEM_ERR_BIT] <= element_matching_rate_bad;
      sts_a_ff[`STS_A_PDM_ERR_BIT] <= mic_clock_gen_bad;
      sts_a_ff[`STS_A_CLK_STOP_BIT] <= stopped_ff;
      sts_b_ff <= '0;
      sts_b_ff[`STS_B_PRI_RATIO_ERR_BIT] <= err_s2_ff[0];
      sts_b_ff[`STS_B_SEC_RATIO_ERR_BIT] <= err_s2_ff[1];
    end
  end

endmodule

`default_nettype wire

// ===== dv/asi_clock_cfg_monitor.sv
// assertion checker for the serial-port clock setup block
`timescale 1ns/10ps
`default_nettype none
module asi_clock_cfg_monitor (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ext_bit_clk,
  // register reads
  input wire logic reg_rd_en,
  input wire asi_clock_cfg_pkg::reg_byte_t reg_addr,
  input wire logic [7:0] reg_rdata,
  // error sources
  input wire logic rate_converter_ratio_bad,
  input wire logic custom_mn_ratio_en,
  input wire logic element_matching_rate_bad,
  input wire logic mic_clock_gen_bad,
  // frame pins
  input wire logic [1:0] fsync_out,
  input wire logic [1:0] fsync_oe,
  input wire logic [1:0] bclk_oe
);
  import asi_clock_cfg_pkg::*;
  wire logic rd_sts = reg_rd_en && reg_addr == 8'h3c;
  // sources held three cycles so the status pipe has settled
  src_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rate_converter_ratio_bad && !custom_mn_ratio_en)[*3] ##0 rd_sts |=> reg_rdata[4])
    else $error("src flag missing");
  src_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    custom_mn_ratio_en[*3] ##0 rd_sts |=> !reg_rdata[4]) else $error("src flag unmasked");
  dem_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    element_matching_rate_bad[*3] ##0 rd_sts |=> reg_rdata[3]) else $error("dem flag missing");
  mic_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mic_clock_gen_bad[*3] ##0 rd_sts |=> reg_rdata[2]) else $error("mic flag missing");
  sts_b_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == 8'h3d |=> reg_rdata[5:0] == 6'h00) else $error("status b low set");
  gen_oe_a: assert property (@(posedge ext_bit_clk) disable iff (!rst_n)
    (fsync_out & ~fsync_oe) == 2'b00) else $error("frame sync undriven");
  int_oe_a: assert property (@(posedge ext_bit_clk) disable iff (!rst_n)
    (bclk_oe & ~fsync_oe) == 2'b00) else $error("bit clock driven in target");
  ext_pulse_a: assert property (@(posedge ext_bit_clk) disable iff (!rst_n)
    $rose(fsync_out[0]) && !bclk_oe[0] |=> !fsync_out[0]) else $error("frame pulse too long");
  cover property (@(posedge ext_bit_clk) $rose(fsync_out[0]) && bclk_oe[0]);
  cover property (@(posedge ext_bit_clk) $rose(fsync_out[1]));
  cover property (@(posedge sys_clk) rd_sts ##1 reg_rdata[1]);
endmodule
bind asi_clock_cfg asi_clock_cfg_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .ext_bit_clk(ext_bit_clk), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .rate_converter_ratio_bad(rate_converter_ratio_bad), .custom_mn_ratio_en(custom_mn_ratio_en),
  .element_matching_rate_bad(element_matching_rate_bad), .mic_clock_gen_bad(mic_clock_gen_bad),
  .fsync_out(fsync_out), .fsync_oe(fsync_oe), .bclk_oe(bclk_oe));
`default_nettype wire

// ===== dv/asi_host_model.sv
// audio host model: bit clock and frame sync of both serial ports
`timescale 1ns/10ps
`default_nettype none
module asi_host_model (
  // bench controls
  input wire logic run,
  input wire logic [13:0] ratio,
  // host pins
  output logic bclk,
  output logic [1:0] fsync
);
  int cnt = 0;
  // odd offset keeps the link clock unrelated to sys_clk
  initial begin
    bclk = 1'b0;
    fsync = 2'b00;
    #3.3;
    forever #6 if (run) bclk = ~bclk;
  end
  // launched on the falling edge, one bit clock wide
  always @(negedge bclk) begin
    cnt <= (ratio == 0 || cnt + 1 >= ratio) ? 0 : cnt + 1;
    fsync <= (ratio != 0 && cnt == 0) ? 2'b11 : 2'b00;
  end
endmodule
`default_nettype wire

// ===== dv/asi_clock_cfg_test.sv
// self-checking bench for the serial-port clock setup block
`timescale 1ns/10ps
`default_nettype none
module asi_clock_cfg_test;
  import asi_clock_cfg_pkg::*;
  logic sys_clk, rst_n, run, wr, rd, rate_bad, custom, elem_bad, mic_bad;
  wire logic ext_clk;
  wire logic [1:0] fs_in;
  reg_byte_t addr, wdata;
  logic [7:0] rdata, d;
  port_bits_t cs;
  logic [1:0] fs_out, fs_oe, bc_oe, bc_out;
  logic [13:0] mratio, r;
  logic [15:0] n;
  logic [31:0] seed = 32'h959004f8;
  int fails = 0, num_checks = 0, cycles = 0;
  asi_clock_cfg #(.STOP_CYCLES(50)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ext_bit_clk(ext_clk), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .controller_select(cs), .rate_converter_ratio_bad(rate_bad),
    .custom_mn_ratio_en(custom), .element_matching_rate_bad(elem_bad),
    .mic_clock_gen_bad(mic_bad), .fsync_in(fs_in), .fsync_out(fs_out), .fsync_oe(fs_oe),
    .bclk_out(bc_out), .bclk_oe(bc_oe));
  asi_host_model i_host (.run(run), .ratio(mratio), .bclk(ext_clk), .fsync(fs_in));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_sts(input logic [3:0] e);
    return {3'b000, e[3] & ~e[2], e[1], e[0], 2'b00};
  endfunction
  // internal clock ticks on every second link edge
  function automatic logic [15:0] exp_per(input logic s, input logic [13:0] v);
    return s ? {1'b0, v, 1'b0} : {2'b00, v};
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr_reg(input reg_byte_t a, input reg_byte_t v);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge sys_clk) #1 wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(input reg_byte_t a, output logic [7:0] v);
    rd = 1'b1;
    addr = a;
    @(posedge sys_clk) #1 rd = 1'b0;
    v = rdata;
    cyc(1);
  endtask
  // first call may start mid-pulse, so callers use the second
  task automatic meas(input int p, output logic [15:0] t);
    int k;
    k = 0;
    t = 0;
    while (fs_out[p] !== 1'b1 && k < 3000) @(negedge ext_clk) k++;
    while (fs_out[p] === 1'b1 && t < 3000) @(negedge ext_clk) t++;
    while (fs_out[p] !== 1'b1 && t < 3000) @(negedge ext_clk) t++;
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    run = 1'b1;
    {wr, rd, rate_bad, custom, elem_bad, mic_bad, cs} = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    mratio = 14'h0000;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // status and unmapped places must ignore writes
    for (int a = 8'h38; a <= 8'h3e; a++) begin
      rd_reg(8'(a), d);
      chk("reset", d, 16'h0000);
      wr_reg(8'(a), a < 8'h3c ? 8'(a) : 8'hff);
      rd_reg(8'(a), d);
      chk("rw", d, a < 8'h3c ? 16'(a) : 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      {rate_bad, custom, elem_bad, mic_bad} = i[3:0];
      cyc(4);
      rd_reg(8'h3c, d);
      chk("sts_a", d, exp_sts(i[3:0]));
    end
    {rate_bad, custom, elem_bad, mic_bad} = 4'h0;
    // config only changes while the port is target
    for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
      r = m == 0 ? 14'd2 : m == 3 ? 14'h0100 : 14'd2 + 14'(xs() % 300);
      wr_reg(8'(8'h38 + 2 * p), {m[1], m[0], r[13:8]});
      wr_reg(8'(8'h39 + 2 * p), r[7:0]);
      rd_reg(8'(8'h38 + 2 * p), d);
      chk("cfg_hi", d, {m[1], m[0], r[13:8]});
      cs[p] = 1'b1;
      cyc(10);
      meas(p, n);
      meas(p, n);
      chk("period", n, exp_per(m[1], r));
      // frame launched on the rising edge of the true or inverted internal clock
      if (m[1]) chk("bclk_phase", bc_out[p], !m[0]);
      chk("bclk_oe", bc_oe[p], m[1]);
      chk("fsync_oe", fs_oe[p], 1'b1);
      cyc(1);
      cs[p] = 1'b0;
      cyc(10);
      chk("target_oe", fs_oe[p], 1'b0);
    end
    for (int k = 0; k < 4; k++) wr_reg(8'(8'h38 + k), k[0] ? 8'h10 : 8'h00);
    for (int k = 0; k < 3; k++) begin
      mratio = k == 1 ? 14'd17 : 14'd16;
      cyc(100);
      rd_reg(8'h3d, d);
      chk("sts_b", d, k == 1 ? 16'h00c0 : 16'h0000);
      rd_reg(8'h3c, d);
      chk("ratio_err", d, k == 1 ? 16'h0080 : 16'h0000);
    end
    // corner case: ratio below the least a controller can make
    wr_reg(8'h39, 8'h01);
    cs[0] = 1'b1;
    cyc(20);
    rd_reg(8'h3d, d);
    chk("ratio_low", d, 16'h0080);
    chk("no_frame", fs_out[0], 1'b0);
    cs[0] = 1'b0;
    for (int k = 0; k < 2; k++) begin
      run = k[0];
      cyc(k[0] ? 20 : 80);
      rd_reg(8'h3c, d);
      chk("clk_stop", d[1], !k[0]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
